// ---- logic/pulse_delay_defines.vh ----
// Constants for the triggered pulse delay generator: register map, fields, timing.
// Assumes a 20 MHz clock (50 ns period); times are given in ns.
`ifndef PULSE_DELAY_DEFINES_VH
`define PULSE_DELAY_DEFINES_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_WIDTH 8'h08
`define REG_SYNC 8'h0c
`define REG_STATUS 8'h10

// Control register fields
`define CTRL_TOGGLE_BIT 0
`define CTRL_POL_BIT 1

// Status register fields
`define STAT_ENABLE_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_VIDEO_BIT 2

// Timing in ns, and the clock period
`define CLK_PERIOD_NS 50
`define DELAY_MIN_NS 100
`define DELAY_MAX_NS 1000000000
`define WIDTH_MIN_NS 50
`define WIDTH_MAX_NS 10000000
`define SYNC_GUARD_NS 50
`define RF_LAG_NS 50

// Cycle counts: least times round up, longest round down
`define DELAY_MIN_CYC ((`DELAY_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_MAX_CYC (`DELAY_MAX_NS / `CLK_PERIOD_NS)
`define WIDTH_MIN_CYC ((`WIDTH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH_MAX_CYC (`WIDTH_MAX_NS / `CLK_PERIOD_NS)
`define SYNC_GUARD_CYC ((`SYNC_GUARD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RF_LAG_CYC ((`RF_LAG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Reset values of the settings
`define DELAY_RESET 32'h00000002
`define WIDTH_RESET 32'h00000001
`define SYNC_RESET 32'h00000000

// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- logic/trigger_edge_sync.v ----
// Three-flop synchroniser for the trigger pin with selectable edge detection.
// Assumes the pin is asynchronous to clock_i; a change counts once flops 2 and 3 agree.
`timescale 1ns/10ps
`default_nettype none
module trigger_edge_sync (
  input wire clock_i,
  input wire rst_i,
  input wire pin_i,
  input wire falling_i,
  output wire edge_o
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg level_ff;
  wire agree;
  wire nxt_level;

  // Synchroniser chain; s1 is read only by s2
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  // Accepted level moves only when the last two stages agree
  assign agree = (s2_ff == s3_ff);
  assign nxt_level = agree ? s3_ff : level_ff;

  // Rising or falling edge of the accepted level
  assign edge_o = falling_i ? (level_ff & ~nxt_level) : (~level_ff & nxt_level); // RULE2
endmodule // trigger_edge_sync
`default_nettype wire

// ---- logic/triggered_pulse_delay_generator.v ----
// Triggered pulse delay generator with AXI4-Lite register access.
// Assumes a single 20 MHz clock, synchronous active-high reset, and a TTL trigger pin.
// How it works
// RULE1: While enabled and idle, each valid trigger edge produces exactly one video pulse.
// RULE2: Polarity bit picks rising or falling trigger edge as valid.
// RULE3: Video pulse rises a programmed delay after the trigger edge.
// RULE4: Video pulse stays high for the programmed width.
// RULE5: Sync pulse starts a programmed interval after video rises, at most width minus 50 ns.
// RULE6: RF gate follows the video pulse about 50 ns later.
// RULE7: Writing the toggle bit inverts the modulation enable.
// RULE8: One width register serves every internal mode.
// RULE9: Status shows modulation active while enabled.
// RULE10: Triggers during a delay or pulse in progress are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_delay_defines.vh"
module triggered_pulse_delay_generator #(
  parameter CNT_W = 32
) (
  input wire clock_i,
  input wire rst_i,
  input wire trigger_input_i,
  output reg video_pulse_o,
  output reg sync_pulse_output_o,
  output reg rf_gate_o,
  output wire mod_active_o,
  input wire [7:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [7:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DELAY = 2'd1;
  localparam [1:0] ST_PULSE = 2'd2;
  localparam [CNT_W-1:0] RF_LAG = `RF_LAG_CYC;
  localparam [CNT_W-1:0] GUARD = `SYNC_GUARD_CYC;
  localparam [CNT_W-1:0] D_MIN = `DELAY_MIN_CYC;
  localparam [CNT_W-1:0] D_MAX = `DELAY_MAX_CYC;
  localparam [CNT_W-1:0] W_MIN = `WIDTH_MIN_CYC;
  localparam [CNT_W-1:0] W_MAX = `WIDTH_MAX_CYC;

  reg enable_ff;
  reg falling_ff;
  reg [CNT_W-1:0] delay_ff;
  reg [CNT_W-1:0] width_ff;
  reg [CNT_W-1:0] sync_ff;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg [CNT_W-1:0] lag_ff;
  reg aw_ff;
  reg w_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  wire trig_edge;
  wire do_write;
  wire [CNT_W-1:0] delay_eff;
  wire [CNT_W-1:0] width_eff;
  wire [CNT_W-1:0] sync_lim;
  wire [CNT_W-1:0] sync_eff;
  wire [31:0] wmerge;

  trigger_edge_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(trigger_input_i),
    .falling_i(falling_ff),
    .edge_o(trig_edge)
  );

  // Settings clamped into their documented ranges
  assign delay_eff = (delay_ff < D_MIN) ? D_MIN : ((delay_ff > D_MAX) ? D_MAX : delay_ff); // RULE3
  assign width_eff = (width_ff < W_MIN) ? W_MIN : ((width_ff > W_MAX) ? W_MAX : width_ff); // RULE4
  assign sync_lim = (width_eff > GUARD) ? (width_eff - GUARD) : {CNT_W{1'b0}};
  assign sync_eff = (sync_ff > sync_lim) ? sync_lim : sync_ff; // RULE5
  assign mod_active_o = enable_ff; // RULE9

  // Trigger sequencer: idle, delay count, pulse count
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (enable_ff && trig_edge) // RULE1
        begin
          nxt_state = ST_DELAY;
          nxt_cnt = delay_eff - 1'b1; // RULE3
        end
      end
      ST_DELAY:
      begin
        if (!enable_ff)
          nxt_state = ST_IDLE;
        else if (cnt_ff == {CNT_W{1'b0}})
        begin
          nxt_state = ST_PULSE;
          nxt_cnt = {CNT_W{1'b0}};
        end
        else
          nxt_cnt = cnt_ff - 1'b1; // RULE10
      end
      ST_PULSE:
      begin
        if (!enable_ff || cnt_ff == width_eff - 1'b1) // RULE4
          nxt_state = ST_IDLE;
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer registers and pulse outputs
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= {CNT_W{1'b0}};
      video_pulse_o <= 1'b0;
      sync_pulse_output_o <= 1'b0;
      rf_gate_o <= 1'b0;
      lag_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      video_pulse_o <= (nxt_state == ST_PULSE);
      // Sync high from its offset to the end of the video pulse
      sync_pulse_output_o <= (nxt_state == ST_PULSE) && (nxt_cnt >= sync_eff); // RULE5
      // RF gate trails video by a shift of RF_LAG cycles
      lag_ff <= {lag_ff[CNT_W-2:0], (nxt_state == ST_PULSE)};
      rf_gate_o <= lag_ff[RF_LAG-1]; // RULE6
    end
  end

  // AXI4-Lite write: capture address and data in either order
  assign s_axi_awready_o = !aw_ff && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_ff && !s_axi_bvalid_o;
  assign do_write = aw_ff && w_ff && !s_axi_bvalid_o;

  // Byte-lane merge of write data over the addressed register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  assign wmerge = merge((awaddr_ff == `REG_DELAY) ? delay_ff :
                        (awaddr_ff == `REG_WIDTH) ? width_ff : sync_ff, wdata_ff, wstrb_ff);

  // Write channel and settings registers
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
      enable_ff <= 1'b0;
      falling_ff <= 1'b0;
      delay_ff <= `DELAY_RESET;
      width_ff <= `WIDTH_RESET;
      sync_ff <= `SYNC_RESET;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `RESP_OKAY;
        case (awaddr_ff)
          `REG_CTRL:
          begin
            if (wstrb_ff[0])
            begin
              if (wdata_ff[`CTRL_TOGGLE_BIT])
                enable_ff <= ~enable_ff; // RULE7
              falling_ff <= wdata_ff[`CTRL_POL_BIT]; // RULE2
            end
          end
          `REG_DELAY: delay_ff <= wmerge;
          `REG_WIDTH: width_ff <= wmerge; // RULE8
          `REG_SYNC: sync_ff <= wmerge;
          `REG_STATUS: s_axi_bresp_o <= `RESP_OKAY;
          default: s_axi_bresp_o <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // AXI4-Lite read: one cycle answer after the address is taken
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `RESP_OKAY;
      case ({s_axi_araddr_i[7:2], 2'b00})
        `REG_CTRL: s_axi_rdata_o <= {30'h0, falling_ff, 1'b0};
        `REG_DELAY: s_axi_rdata_o <= delay_ff;
        `REG_WIDTH: s_axi_rdata_o <= width_ff;
        `REG_SYNC: s_axi_rdata_o <= sync_ff;
        `REG_STATUS: s_axi_rdata_o <= {29'h0, video_pulse_o, (state_ff != ST_IDLE), enable_ff}; // RULE9
        default:
        begin
          s_axi_rdata_o <= 32'h00000000;
          s_axi_rresp_o <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end
endmodule // triggered_pulse_delay_generator
`default_nettype wire

// ---- verif/pulse_gen_asserts.sv ----
// Checker for the pulse generator's port timing.
// Assumes it is bound to the top module; sees ports only.
`timescale 1ns/10ps
`default_nettype none
module pulse_gen_asserts (
  input wire clock_i,
  input wire rst_i,
  input wire video_pulse_o,
  input wire sync_pulse_output_o,
  input wire rf_gate_o,
  input wire mod_active_o,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Bus handshake steps
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  // Bus answers
  a_write_resp_time: assert property (wr_taken |-> ##2 s_axi_bvalid_o)
    else $error("write response not two cycles after request");
  a_read_resp_time: assert property (rd_taken |=> s_axi_rvalid_o)
    else $error("read response not one cycle after request");
  a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read response dropped or changed");
  a_rvalid_clears: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer not withdrawn after it was taken");
  // Pulse outputs
  a_rf_gate_lag: assert property ($rose(video_pulse_o) |=> $rose(rf_gate_o))
    else $error("gate did not follow video by one cycle");
  a_sync_in_video: assert property (sync_pulse_output_o |-> video_pulse_o)
    else $error("sync high outside video");
  a_off_no_video: assert property (!mod_active_o [*3] |-> !video_pulse_o)
    else $error("video while modulation off");
endmodule // pulse_gen_asserts
bind triggered_pulse_delay_generator pulse_gen_asserts u_pulse_gen_asserts (.clock_i, .rst_i, .video_pulse_o,
  .sync_pulse_output_o, .rf_gate_o, .mod_active_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o);
`default_nettype wire

// ---- verif/ttl_trigger_src.sv ----
// Model of the external TTL trigger source.
// Assumes the bench asks for a level; the pin follows lag_i+1 cycles later.
`timescale 1ns/10ps
`default_nettype none
module ttl_trigger_src (
  input wire logic clock_i,
  input wire logic level_i,
  input wire logic [3:0] lag_i,
  output var logic pin_o
);
  logic [3:0] cnt_ff;
  initial
  begin
    pin_o = 1'b0;
    cnt_ff = 4'h0;
  end
  // Pin moves to the asked level after the lag
  always @(posedge clock_i)
  begin
    if (level_i == pin_o) cnt_ff <= 4'h0;
    else if (cnt_ff >= lag_i) pin_o <= level_i;
    else cnt_ff <= cnt_ff + 4'h1;
  end
endmodule // ttl_trigger_src
`default_nettype wire

// ---- verif/triggered_pulse_delay_generator_test.sv ----
// Bench for the pulse generator: bus tasks and trigger sequences.
// Assumes the defines header and a 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_delay_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module triggered_pulse_delay_generator_test;
  logic clock_i, rst_i, lvl, pin, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, video, sync, rf, act, vq, sq, rq;
  logic [3:0] lag;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int err_count, tests_run, cyc, pulses, hi_len, sync_off, t_rise, t0, l4, rf_off;
  ttl_trigger_src u_ttl_trigger_src (.clock_i(clock_i), .level_i(lvl), .lag_i(lag), .pin_o(pin));
  triggered_pulse_delay_generator u_triggered_pulse_delay_generator (.clock_i(clock_i), .rst_i(rst_i),
    .trigger_input_i(pin), .video_pulse_o(video), .sync_pulse_output_o(sync), .rf_gate_o(rf),
    .mod_active_o(act), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  // Clock
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  // Pulse count, width, sync offset, and the hang limit
  always @(negedge clock_i)
  begin
    if (video && !vq) pulses++;
    if (video && !vq) t_rise = cyc;
    hi_len = video ? (vq ? hi_len + 1 : 1) : hi_len;
    if (sync && !sq) sync_off = cyc - t_rise;
    if (rf && !rq) rf_off = cyc - t_rise;
    vq = video;
    sq = sync;
    rq = rf;
    cyc++;
    if (cyc == 5000) err_count++;
    if (cyc == 5000) test_done();
  end
  // Bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clock_i); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge clock_i); while (!wready); wvalid <= 1'b0; end
    join
    while (!bvalid) @(posedge clock_i);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clock_i);
  endtask
  // Bus read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clock_i);
    `CHK(rd, e)
  endtask
  // Move the trigger pin, then wait
  task automatic fire(input logic l, input int n);
    t0 = cyc;
    lvl <= l;
    repeat (n) @(posedge clock_i);
  endtask
  // Verdict
  task test_done;
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst_i, lvl, lag, awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    rst_i = 1'b1;
    {err_count, tests_run, cyc, pulses, hi_len, sync_off, t_rise, rf_off, vq, sq, rq} = '0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd_chk(`REG_DELAY, `DELAY_RESET);
    rd_chk(`REG_WIDTH, `WIDTH_RESET);
    rd_chk(`REG_SYNC, `SYNC_RESET);
    rd_chk(`REG_STATUS, 32'h00000000);
    rd_chk(8'h14, 32'h00000000);
    `CHK(rs, `RESP_SLVERR)
    wr(`REG_WIDTH, 32'h00000005);
    wr(`REG_SYNC, 32'h00000002);
    wr(`REG_DELAY, 32'h00000004);
    wr(`REG_CTRL, 32'h00000001);
    wr(`REG_STATUS, 32'h000000ff);
    `CHK(rs, `RESP_OKAY)
    rd_chk(`REG_STATUS, 32'h00000001);
    `CHK(act, 1'b1)
    rd_chk(`REG_CTRL, 32'h00000000);
    rd_chk(`REG_WIDTH, 32'h00000005);
    fire(1'b1, 40);
    l4 = t_rise - t0;
    `CHK(pulses, 1)
    `CHK(hi_len, 5)
    `CHK(sync_off, 2)
    `CHK(rf_off, `RF_LAG_CYC)
    wr(`REG_DELAY, 32'h00000008);
    fire(1'b0, 40);
    `CHK(pulses, 1)
    fire(1'b1, 40);
    `CHK(pulses, 2)
    `CHK(t_rise - t0 - l4, 4)
    // Slow source, edges inside the busy time
    wr(`REG_DELAY, 32'h00000014);
    lag <= 4'h3;
    fire(1'b0, 8);
    fire(1'b1, 8);
    fire(1'b0, 8);
    fire(1'b1, 60);
    `CHK(pulses, 3)
    wr(`REG_CTRL, 32'h00000002);
    wr(`REG_SYNC, 32'h00000009);
    fire(1'b0, 60);
    `CHK(pulses, 4)
    `CHK(sync_off, 4)
    fire(1'b1, 60);
    `CHK(pulses, 4)
    wr(`REG_CTRL, 32'h00000003);
    rd_chk(`REG_CTRL, 32'h00000002);
    `CHK(act, 1'b0)
    fire(1'b0, 60);
    `CHK(pulses, 4)
    test_done();
  end
endmodule // triggered_pulse_delay_generator_test
`default_nettype wire
